// ==== design/serial_port_regs.vh ====
// Register indices, field positions, reset values and timing counts
// for the four-mode serial port.
// Assumes byte address = 4 * index on a 32-bit APB bus.
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IDX_INT_FLAGS 8'hFB
`define IDX_CTRL_HIGH 8'hFC
`define IDX_CTRL_LOW 8'hFD
`define IDX_DATA 8'hFE
`define IDX_BAUD_DIV 8'hFF
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CH_MODE_HI 7
`define CH_MODE_LO 6
`define CH_MP_EN 5
`define CH_RX_EN 4
`define CH_TX_NINTH 3
`define CH_RX_NINTH 2
`define CL_PAR_GEN 7
`define CL_TX_PSEL 6
`define CL_RX_PSEL 5
`define CL_PAR_ERR 4
`define CL_CLK_HI 3
`define CL_CLK_LO 2
`define IF_TX_STATUS 0
`define IF_RX_STATUS 1
`define IF_TX_IRQ 2
`define IF_RX_IRQ 3
// ----------------------------------------------------------------
// Mode encodings and reset values
// ----------------------------------------------------------------
`define MODE_SYNC 2'h0
`define MODE_ASYNC8 2'h1
`define MODE_FIXED9 2'h2
`define MODE_VAR9 2'h3
`define RESET_BYTE 8'h00
// ----------------------------------------------------------------
// Timing counts, in sixteenth-bit ticks
// ----------------------------------------------------------------
`define SUB_LAST 4'hF
`define SUB_MID 4'h7
`define SUB_SYNC_SAMPLE 4'hB
`endif

// ==== design/four_mode_serial_port.v ====
// Four-mode serial port: synchronous master shifter, 8-bit async,
// fixed-rate and variable-rate 9-bit async, with an APB register file.
// Assumes one 50 MHz clock; the receive line is a pin and is
// synchronised here, and the CPU acknowledge inputs are on this clock.
`timescale 1ns/1ps
`include "serial_port_regs.vh"

module four_mode_serial_port (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial pins
  input wire rxd_in,
  output reg rxd_out,
  output reg rxd_oe,
  output reg txd,
  // Interrupt requests and CPU acknowledges
  output reg tx_irq_request,
  output reg rx_irq_request,
  input wire tx_irq_ack,
  input wire rx_irq_ack
);

  // ----------------------------------------------------------------
  // Constants and functions
  // ----------------------------------------------------------------
  localparam TX_IDLE = 1'b0;
  localparam TX_RUN = 1'b1;
  localparam RX_IDLE = 1'b0;
  localparam RX_RUN = 1'b1;

  // Byte address match of a register index.
  function reg_hit;
    input [11:0] addr;
    input [7:0] idx;
    begin
      reg_hit = (addr == {2'b00, idx, 2'b00});
    end
  endfunction

  // Last prescaler count for the selected serial clock.
  function [2:0] pre_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: pre_limit = 3'h7;
        2'h1: pre_limit = 3'h3;
        2'h2: pre_limit = 3'h1;
        default: pre_limit = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and signals
  // ----------------------------------------------------------------
  reg [7:0] ctrl_high_r;
  reg [7:0] ctrl_low_r;
  reg [7:0] baud_div_r;
  reg [7:0] tx_buf_r;
  reg tx_pend_r;
  reg [7:0] rx_buf_r;
  reg tx_status_r;
  reg rx_status_r;
  reg [2:0] pre_cnt_r;
  reg [7:0] baud_cnt_r;
  reg rx_s1_r;
  reg rx_s2_r;
  reg rx_s3_r;
  reg rx_line_r;
  reg rx_prev_r;
  reg tx_state_r;
  reg sync_rx_r;
  reg [10:0] tx_shift_r;
  reg [3:0] tx_bits_r;
  reg [3:0] tx_sub_r;
  reg [7:0] sync_in_r;
  reg rx_state_r;
  reg [3:0] rx_sub_r;
  reg [3:0] rx_idx_r;
  reg [7:0] rx_data_r;

  wire [1:0] mode = ctrl_high_r[`CH_MODE_HI:`CH_MODE_LO];
  wire mp_en = ctrl_high_r[`CH_MP_EN];
  wire par_gen = ctrl_low_r[`CL_PAR_GEN];
  wire wr_en = psel & penable & pready & pwrite;
  wire rx_en_set = wr_en & reg_hit(paddr, `IDX_CTRL_HIGH) &
                   pwdata[`CH_RX_EN] & ~ctrl_high_r[`CH_RX_EN];
  wire sclk_en = (pre_cnt_r == pre_limit(ctrl_low_r[`CL_CLK_HI:`CL_CLK_LO]));
  reg tick16;
  wire tx_end_bit = (tx_state_r == TX_RUN) & tick16 &
                    (tx_sub_r == `SUB_LAST);
  wire rx_mid = (rx_state_r == RX_RUN) & tick16 & (rx_sub_r == `SUB_MID);
  wire nine_bit = mode[1];
  wire tx_ninth = par_gen ?
                  (ctrl_low_r[`CL_TX_PSEL] ^ (^tx_buf_r)) :
                  ctrl_high_r[`CH_TX_NINTH];
  wire rx_par_exp = ctrl_low_r[`CL_RX_PSEL] ^ (^rx_data_r);
  reg tx_done_set;
  reg rx_done_set;
  reg rx_irq_set;
  reg rx_par_bad;

  // ----------------------------------------------------------------
  // Baud generation
  // ----------------------------------------------------------------
  // clock select
  // The prescaler yields one enable per selected serial clock period.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_r <= 3'h0;
      baud_cnt_r <= 8'h00;
    end else begin
      pre_cnt_r <= sclk_en ? 3'h0 : pre_cnt_r + 3'h1;
      if (sclk_en) begin
        baud_cnt_r <= (baud_cnt_r >= baud_div_r) ? 8'h00 :
                      baud_cnt_r + 8'h01;
      end
    end
  end

  // Sixteen ticks make one bit. The divisor counter runs free, so the
  // first bit of a frame may be up to one tick short; that costs at most
  // one sixteenth of a bit.
  always @* begin
    if (mode == `MODE_FIXED9) begin
      tick16 = 1'b1;
    end else begin
      tick16 = sclk_en & (baud_cnt_r >= baud_div_r);
    end
  end

  // ----------------------------------------------------------------
  // Receive pin synchroniser
  // ----------------------------------------------------------------
  // Three stages; the filtered level only moves when stages two and
  // three agree, which rejects a single-cycle glitch.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_line_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd_in;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_line_r <= rx_s3_r;
      end
      rx_prev_r <= rx_line_r;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and synchronous engine
  // ----------------------------------------------------------------
  // One engine serves both directions of mode 0, since that mode is
  // half duplex, and the transmit side of the async modes.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_state_r <= TX_IDLE;
      sync_rx_r <= 1'b0;
      tx_shift_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_sub_r <= 4'h0;
      sync_in_r <= 8'h00;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          tx_sub_r <= 4'h0;
          if (mode == `MODE_SYNC && rx_en_set) begin
            tx_state_r <= TX_RUN;
            sync_rx_r <= 1'b1;
            tx_shift_r <= 11'h7FF;
            tx_bits_r <= 4'h8;
          end else if (tx_pend_r) begin
            tx_state_r <= TX_RUN;
            sync_rx_r <= 1'b0;
            if (mode == `MODE_SYNC) begin
              tx_shift_r <= {3'b111, tx_buf_r};
              tx_bits_r <= 4'h8;
            end else if (nine_bit) begin
              tx_shift_r <= {1'b1, tx_ninth, tx_buf_r, 1'b0};
              tx_bits_r <= 4'hB;
            end else begin
              tx_shift_r <= {2'b11, tx_buf_r, 1'b0};
              tx_bits_r <= 4'hA;
            end
          end
        end
        TX_RUN: begin
          if (tick16) begin
            tx_sub_r <= tx_sub_r + 4'h1;
          end
          // Sample on the rising half of the shift clock.
          if (tick16 && tx_sub_r == `SUB_SYNC_SAMPLE) begin
            sync_in_r <= {rx_line_r, sync_in_r[7:1]};
          end
          if (tx_end_bit) begin
            tx_shift_r <= {1'b1, tx_shift_r[10:1]};
            tx_bits_r <= tx_bits_r - 4'h1;
            if (tx_bits_r == 4'h1) begin
              tx_state_r <= TX_IDLE;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  // Completion events of the engine.
  always @* begin
    tx_done_set = 1'b0;
    if (tx_end_bit && !sync_rx_r) begin
      if (mode == `MODE_SYNC) begin
        tx_done_set = (tx_bits_r == 4'h1);
      end else begin
        tx_done_set = (tx_bits_r == 4'h2);
      end
    end
  end

  // Pin drivers, all registered.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else if (tx_state_r == TX_RUN && mode == `MODE_SYNC) begin
      txd <= tx_sub_r[3];
      rxd_out <= tx_shift_r[0];
      rxd_oe <= ~sync_rx_r;
    end else if (tx_state_r == TX_RUN) begin
      txd <= tx_shift_r[0];
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      txd <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  // Bit index 0 is the start bit, 1..8 the data, 9 the stop or ninth.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_state_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_idx_r <= 4'h0;
      rx_data_r <= 8'h00;
    end else begin
      case (rx_state_r)
        RX_IDLE: begin
          rx_sub_r <= 4'h0;
          rx_idx_r <= 4'h0;
          if (mode != `MODE_SYNC && ctrl_high_r[`CH_RX_EN] &&
              rx_prev_r && !rx_line_r) begin
            rx_state_r <= RX_RUN;
          end
        end
        RX_RUN: begin
          if (tick16) begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == `SUB_LAST) begin
              rx_idx_r <= rx_idx_r + 4'h1;
            end
          end
          if (rx_mid) begin
            if (rx_idx_r == 4'h0 && rx_line_r) begin
              rx_state_r <= RX_IDLE;
            end else if (rx_idx_r >= 4'h1 && rx_idx_r <= 4'h8) begin
              rx_data_r <= {rx_line_r, rx_data_r[7:1]};
            end else if (rx_idx_r == 4'h9) begin
              // The stop of a 9-bit frame is not examined.
              rx_state_r <= RX_IDLE;
            end
          end
          if (mode == `MODE_SYNC || !ctrl_high_r[`CH_RX_EN]) begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end

  // Receive completion, interrupt gating and parity check.
  always @* begin
    rx_done_set = 1'b0;
    rx_irq_set = 1'b0;
    rx_par_bad = 1'b0;
    if (tx_end_bit && sync_rx_r && tx_bits_r == 4'h1) begin
      rx_done_set = 1'b1;
      rx_irq_set = 1'b1;
    end else if (rx_mid && rx_idx_r == 4'h9 &&
                 ctrl_high_r[`CH_RX_EN] && mode != `MODE_SYNC) begin
      rx_done_set = 1'b1;
      if (nine_bit) begin
        rx_irq_set = ~mp_en | rx_line_r;
        rx_par_bad = par_gen & (rx_line_r != rx_par_exp);
      end else begin
        rx_irq_set = ~mp_en | rx_line_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Hardware set wins over acknowledge and software clear.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_irq_request <= 1'b0;
      rx_irq_request <= 1'b0;
      tx_status_r <= 1'b0;
      rx_status_r <= 1'b0;
    end else begin
      tx_irq_request <= tx_done_set | (tx_irq_request & ~tx_irq_ack);
      rx_irq_request <= rx_irq_set | (rx_irq_request & ~rx_irq_ack);
      tx_status_r <= tx_done_set | (tx_status_r & ~(wr_en &
                     reg_hit(paddr, `IDX_INT_FLAGS) &
                     pwdata[`IF_TX_STATUS]));
      rx_status_r <= rx_irq_set | (rx_status_r & ~(wr_en &
                     reg_hit(paddr, `IDX_INT_FLAGS) &
                     pwdata[`IF_RX_STATUS]));
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software writes come first; hardware updates below them win the
  // same bit, so an event is never lost to a concurrent write.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_high_r <= `RESET_BYTE;
      ctrl_low_r <= `RESET_BYTE;
      baud_div_r <= `RESET_BYTE;
      tx_buf_r <= `RESET_BYTE;
      tx_pend_r <= 1'b0;
      rx_buf_r <= `RESET_BYTE;
    end else begin
      if (wr_en && reg_hit(paddr, `IDX_CTRL_HIGH)) begin
        ctrl_high_r <= {pwdata[7:2], 2'b00};
      end
      if (wr_en && reg_hit(paddr, `IDX_CTRL_LOW)) begin
        ctrl_low_r <= {pwdata[7:2], 2'b00};
      end
      if (wr_en && reg_hit(paddr, `IDX_BAUD_DIV)) begin
        baud_div_r <= pwdata[7:0];
      end
      if (wr_en && reg_hit(paddr, `IDX_DATA)) begin
        tx_buf_r <= pwdata[7:0];
        tx_pend_r <= 1'b1;
      end else if (tx_state_r == TX_IDLE && !(mode == `MODE_SYNC &&
                   rx_en_set)) begin
        tx_pend_r <= 1'b0;
      end
      if (rx_done_set && nine_bit && !sync_rx_r) begin
        ctrl_high_r[`CH_RX_NINTH] <= rx_line_r;
      end
      if (rx_par_bad) begin
        ctrl_low_r[`CL_PAR_ERR] <= 1'b1;
      end
      if (rx_done_set) begin
        rx_buf_r <= sync_rx_r ? sync_in_r : rx_data_r;
      end
      // A sync receive is one byte; the enable drops when it ends.
      if (rx_done_set && sync_rx_r) begin
        ctrl_high_r[`CH_RX_EN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One wait state, so that read data and ready both come from flops.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready &
                 ~(reg_hit(paddr, `IDX_INT_FLAGS) |
                   reg_hit(paddr, `IDX_CTRL_HIGH) |
                   reg_hit(paddr, `IDX_CTRL_LOW) |
                   reg_hit(paddr, `IDX_DATA) |
                   reg_hit(paddr, `IDX_BAUD_DIV));
      prdata <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        if (reg_hit(paddr, `IDX_INT_FLAGS)) begin
          prdata <= {28'h0000000, rx_irq_request, tx_irq_request,
                     rx_status_r, tx_status_r};
        end else if (reg_hit(paddr, `IDX_CTRL_HIGH)) begin
          prdata <= {24'h000000, ctrl_high_r};
        end else if (reg_hit(paddr, `IDX_CTRL_LOW)) begin
          prdata <= {24'h000000, ctrl_low_r};
        end else if (reg_hit(paddr, `IDX_DATA)) begin
          prdata <= {24'h000000, rx_buf_r};
        end else if (reg_hit(paddr, `IDX_BAUD_DIV)) begin
          prdata <= {24'h000000, baud_div_r};
        end
      end
    end
  end

endmodule

// ==== bench/serial_port_properties.sv ====
// Concurrent checks on the serial port's top-level ports.
// Assumes one clock domain and is attached by the bind at the foot.
`timescale 1ns/1ps
module serial_port_properties (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Serial pins and requests
  input wire rxd_in,
  input wire rxd_out,
  input wire rxd_oe,
  input wire txd,
  input wire tx_irq_request,
  input wire rx_irq_request,
  input wire tx_irq_ack,
  input wire rx_irq_ack
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_rdy_wait;
    psel && $rose(penable) |-> !pready ##1 pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("pready not in second access cycle");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready held over one cycle");
  property p_err_rdy;
    pslverr |-> pready && psel && penable;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("pslverr outside an answer");
  property p_rd_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("prdata not zero between answers");
  // stop bit follows; the pin register lags the request by one.
  property p_tx_stop;
    $rose(tx_irq_request) |=> txd [*8];
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("tx request not at a high stop level");
  property p_tx_ack;
    tx_irq_ack |=> !tx_irq_request;
  endproperty
  a_tx_ack: assert property (p_tx_ack)
    else $error("tx request survived acknowledge");
  property p_rx_ack;
    rx_irq_ack |=> !rx_irq_request;
  endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("rx request survived acknowledge");
  property p_release;
    !rxd_oe |-> rxd_out;
  endproperty
  a_release: assert property (p_release)
    else $error("rxd_out low while not driving");
  property p_sync_clk;
    $rose(rxd_oe) |-> ##[0:300] $fell(txd);
  endproperty
  a_sync_clk: assert property (p_sync_clk)
    else $error("no shift clock while driving rxd");
  c_tx: cover property ($rose(tx_irq_request));
  c_rx: cover property ($rose(rx_irq_request));
  c_err: cover property (pslverr);
endmodule
bind four_mode_serial_port serial_port_properties u_chk (.*);

// ==== bench/serial_peer.sv ====
// Far-end partner: async transceiver and mode-0 clocked slave.
// Assumes the bench sets bit length in system clocks and the mode.
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire clock,
  // Pins seen from the far end
  input wire txd,
  input wire pin_level,
  output logic line_out,
  // Setup from the bench
  input wire sync_mode,
  input wire [3:0] frame_bits,
  input wire [15:0] bit_clks
);
  logic [10:0] got;
  logic [7:0] sync_got;
  logic [7:0] sync_tx;
  int got_count;
  int sync_left;
  initial begin
    line_out = 1'b1;
    got_count = 0;
    sync_left = 0;
  end
  // mid-bit capture, no stop after the last sample.
  always begin
    @(negedge txd);
    if (!sync_mode) begin
      repeat (bit_clks / 2) @(posedge clock);
      for (int i = 0; i < frame_bits; i++) begin
        got[i] = txd;
        if (i < frame_bits - 1) repeat (bit_clks) @(posedge clock);
      end
      got_count++;
    end
  end
  // mode-0 capture, LSB first on the rising clock.
  always @(posedge txd) if (sync_mode) sync_got <= {pin_level, sync_got[7:1]};
  // mode-0 answer; an idle line wanders so stale bits never pass.
  always @(negedge txd) begin
    if (sync_mode && sync_left > 0) begin
      line_out <= sync_tx[0];
      sync_tx <= sync_tx >> 1;
      sync_left <= sync_left - 1;
    end else if (sync_mode) begin
      line_out <= ~line_out;
    end
  end
  // one async frame, then the line returns to mark.
  task automatic send_frame(input logic [10:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      line_out <= b[i];
      repeat (bit_clks - 1) @(posedge clock);
    end
    @(posedge clock);
    line_out <= 1'b1;
  endtask
  task automatic sync_load(input logic [7:0] d);
    sync_tx = d;
    sync_left = 8;
  endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the four-mode serial port.
// Assumes the port header and the partner model alongside.
`timescale 1ns/1ps
`include "serial_port_regs.vh"
module testbench;
  // Bench-driven signals.
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic tx_irq_ack = 1'b0;
  logic rx_irq_ack = 1'b0;
  logic sync_mode = 1'b0;
  logic [3:0] frame_bits = 4'hA;
  logic [15:0] bit_clks = 16'h0010;
  wire [31:0] prdata;
  wire pready, pslverr, rxd_out, rxd_oe, txd, peer_line;
  wire tx_irq_request, rx_irq_request;
  // The shared data pin: whoever enables drives it.
  wire rxd_in = rxd_oe ? rxd_out : peer_line;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic e;
  four_mode_serial_port u_dut (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .tx_irq_request(tx_irq_request), .rx_irq_request(rx_irq_request),
    .tx_irq_ack(tx_irq_ack), .rx_irq_ack(rx_irq_ack));
  serial_peer u_peer (.clock(clock), .txd(txd), .pin_level(rxd_in),
    .line_out(peer_line), .sync_mode(sync_mode), .frame_bits(frame_bits),
    .bit_clks(bit_clks));
  always #10 clock = ~clock;
  // Run length is well under this; reaching it means a hang.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      err_total++;
    end
  endtask
  // One APB transfer held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] i, input logic [31:0] x);
    apb(1'b0, i, 8'h00);
    chk(rd, x);
  endtask
  task automatic cfg(input logic [7:0] h, input logic [7:0] l,
                     input logic [7:0] dv);
    apb(1'b1, `IDX_CTRL_HIGH, h);
    apb(1'b1, `IDX_CTRL_LOW, l);
    apb(1'b1, `IDX_BAUD_DIV, dv);
  endtask
  task automatic ack(input logic t);
    @(posedge clock);
    tx_irq_ack <= t;
    rx_irq_ack <= !t;
    @(posedge clock);
    tx_irq_ack <= 1'b0;
    rx_irq_ack <= 1'b0;
    @(posedge clock);
    chk({30'h0, tx_irq_request, rx_irq_request}, 32'h0);
  endtask
  // Send a byte, compare the wire frame, then flags and requests.
  task automatic tx_frame(input logic [7:0] d, input logic [10:0] x);
    int n0;
    logic [10:0] m;
    n0 = u_peer.got_count;
    m = (11'h1 << frame_bits) - 11'h1;
    apb(1'b1, `IDX_DATA, d);
    while (u_peer.got_count == n0) @(posedge clock);
    chk({21'h0, u_peer.got & m}, {21'h0, x});
    chk({31'h0, tx_irq_request}, 32'h1);
    ack(1'b1);
    apb(1'b0, `IDX_INT_FLAGS, 8'h00);
    chk(rd & 32'hF, 32'h1);
    apb(1'b1, `IDX_INT_FLAGS, 8'h01);
  endtask
  task automatic rx_frame(input logic [10:0] b, input int n, input logic x);
    u_peer.send_frame(b, n);
    chk({31'h0, rx_irq_request}, {31'h0, x});
    if (x) ack(1'b0);
  endtask
  task automatic t_regs;
    for (int k = 0; k < 5; k++) rdchk(8'hFB + 8'(k), 32'h0);
    apb(1'b1, `IDX_BAUD_DIV, 8'hA7);
    rdchk(`IDX_BAUD_DIV, 32'hA7);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, e}, 32'h1);
    chk(rd, 32'h0);
    $display("register test done");
  endtask
  task automatic t_rates;
    logic [7:0] d;
    for (int s = 0; s < 5; s++) begin
      d = 8'hA5 ^ 8'(s);
      bit_clks <= (s < 4) ? (16'h0080 >> s) : 16'h0020;
      cfg(8'h40, (s < 4) ? 8'(s << 2) : 8'h0C, 8'((s == 4) ? 1 : 0));
      tx_frame(d, {2'b01, d, 1'b0});
    end
    $display("rate test done");
  endtask
  task automatic t_ninth;
    bit_clks <= 16'h0010;
    frame_bits <= 4'hB;
    cfg(8'h88, 8'h0C, 8'h05);
    tx_frame(8'h3C, {2'b11, 8'h3C, 1'b0});
    cfg(8'hC8, 8'h8C, 8'h00);
    tx_frame(8'h3C, {2'b10, 8'h3C, 1'b0});
    cfg(8'hC0, 8'hCC, 8'h00);
    tx_frame(8'h3C, {2'b11, 8'h3C, 1'b0});
    $display("ninth bit test done");
  endtask
  task automatic t_rx;
    frame_bits <= 4'hA;
    cfg(8'h70, 8'h0C, 8'h00);
    rx_frame({2'b00, 8'h55, 1'b0}, 10, 1'b0);
    cfg(8'h50, 8'h0C, 8'h00);
    rx_frame({2'b01, 8'hC3, 1'b0}, 10, 1'b1);
    rdchk(`IDX_DATA, 32'hC3);
    rdchk(`IDX_INT_FLAGS, 32'h2);
    apb(1'b1, `IDX_INT_FLAGS, 8'h02);
    tx_frame(8'h77, {2'b01, 8'h77, 1'b0});
    rdchk(`IDX_DATA, 32'hC3);
    cfg(8'hF0, 8'h0C, 8'h00);
    rx_frame({2'b10, 8'h11, 1'b0}, 11, 1'b0);
    rx_frame({2'b11, 8'h42, 1'b0}, 11, 1'b1);
    rdchk(`IDX_DATA, 32'h42);
    rdchk(`IDX_CTRL_HIGH, 32'hF4);
    cfg(8'hD0, 8'h0C, 8'h00);
    rx_frame({2'b10, 8'h24, 1'b0}, 11, 1'b1);
    rdchk(`IDX_CTRL_HIGH, 32'hD0);
    cfg(8'hD0, 8'h8C, 8'h00);
    rx_frame({2'b10, 8'h01, 1'b0}, 11, 1'b1);
    rdchk(`IDX_CTRL_LOW, 32'h9C);
    cfg(8'hD0, 8'hAC, 8'h00);
    rx_frame({2'b10, 8'h01, 1'b0}, 11, 1'b1);
    rdchk(`IDX_CTRL_LOW, 32'hAC);
    apb(1'b1, `IDX_INT_FLAGS, 8'h02);
    $display("receive test done");
  endtask
  task automatic t_sync;
    sync_mode <= 1'b1;
    cfg(8'h00, 8'h0C, 8'h00);
    apb(1'b1, `IDX_DATA, 8'h96);
    wait (tx_irq_request === 1'b1);
    chk({24'h0, u_peer.sync_got}, 32'h96);
    rdchk(`IDX_INT_FLAGS, 32'h5);
    ack(1'b1);
    apb(1'b1, `IDX_INT_FLAGS, 8'h01);
    u_peer.sync_load(8'h5A);
    apb(1'b1, `IDX_CTRL_HIGH, 8'h10);
    wait (rx_irq_request === 1'b1);
    rdchk(`IDX_DATA, 32'h5A);
    rdchk(`IDX_INT_FLAGS, 32'hA);
    ack(1'b0);
    $display("sync test done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs;
    t_rates;
    t_ninth;
    t_rx;
    t_sync;
    complete_run;
  end
endmodule
